// >>> rtl/sgd_cfg.svh
`ifndef SGD_CFG_SVH
`define SGD_CFG_SVH

// bus and pin group widths
`define SGD_ADDR_W          8
`define SGD_DATA_W          8
`define SGD_BIDIR_N         6
`define SGD_OUTONLY_N       2
`define SGD_EVENT_N         2
`define SGD_INONLY_N        2

// data registers
`define SGD_OFF_BIDIR_DOUT  8'h08
`define SGD_OFF_BIDIR_DIN   8'h09
`define SGD_OFF_OUT_DOUT    8'h0A
`define SGD_OFF_MISC_DIN    8'h0B

// per-pin configuration registers
`define SGD_OFF_BIDIR_OE    8'h20
`define SGD_OFF_BIDIR_OTYPE 8'h21
`define SGD_OFF_BIDIR_PU    8'h22
`define SGD_OFF_BIDIR_LOCK  8'h23
`define SGD_OFF_OUT_OE      8'h24
`define SGD_OFF_OUT_OTYPE   8'h25
`define SGD_OFF_OUT_PU      8'h26
`define SGD_OFF_OUT_LOCK    8'h27

// reset values
`define SGD_RST_BIDIR_DOUT  6'h3F
`define SGD_RST_OUT_DOUT    2'h3
`define SGD_RST_BIDIR_OE    6'h00
`define SGD_RST_BIDIR_OTYPE 6'h00
`define SGD_RST_BIDIR_PU    6'h3F
`define SGD_RST_OUT_OE      2'h3
`define SGD_RST_OUT_OTYPE   2'h0
`define SGD_RST_OUT_PU      2'h3

// field positions inside the input registers
`define SGD_BIDIR_DIN_LSB   0
`define SGD_EVENT_DIN_LSB   6
`define SGD_OUT_DIN_LSB     0
`define SGD_INONLY_DIN_LSB  2

`endif

// >>> rtl/sgd_pkg.sv
package sgd_pkg;

`include "sgd_cfg.svh"

    typedef logic [`SGD_ADDR_W-1:0] sgd_addr_t;
    typedef logic [`SGD_DATA_W-1:0] sgd_data_t;

    // one register bus request
    typedef struct packed {
        sgd_addr_t addr;
        sgd_data_t wdata;
        logic      wr;
        logic      rd;
    } sgd_bus_s;

    // drive of the bidirectional pin group
    typedef struct packed {
        logic [`SGD_BIDIR_N-1:0] o;
        logic [`SGD_BIDIR_N-1:0] oe;
        logic [`SGD_BIDIR_N-1:0] pu;
    } sgd_bidir_drv_s;

    // drive of the output-only pin group
    typedef struct packed {
        logic [`SGD_OUTONLY_N-1:0] o;
        logic [`SGD_OUTONLY_N-1:0] oe;
        logic [`SGD_OUTONLY_N-1:0] pu;
    } sgd_out_drv_s;

    typedef enum {
        SGD_REG_NONE,
        SGD_REG_BIDIR_DOUT,
        SGD_REG_BIDIR_DIN,
        SGD_REG_OUT_DOUT,
        SGD_REG_MISC_DIN,
        SGD_REG_BIDIR_OE,
        SGD_REG_BIDIR_OTYPE,
        SGD_REG_BIDIR_PU,
        SGD_REG_BIDIR_LOCK,
        SGD_REG_OUT_OE,
        SGD_REG_OUT_OTYPE,
        SGD_REG_OUT_PU,
        SGD_REG_OUT_LOCK
    } sgd_reg_e;

endpackage

// >>> rtl/sgd_lock_reg.sv
`timescale 1ns/1ps

// bank of per-pin bits that a lock freezes against writes and soft preset
module sgd_lock_reg #(
    parameter int              W   = 6,
    parameter logic [W-1:0]    RST = '0
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          sw_rst,
    input  wire logic          wr_en,
    input  wire logic [W-1:0]  wdata,
    input  wire logic [W-1:0]  lock,
    output logic      [W-1:0]  q
);

    logic [W-1:0] q_r;
    logic [W-1:0] load_nxt;
    logic         upd;

    // soft reset outranks a write in the same cycle
    assign load_nxt = sw_rst ? RST : wdata;
    assign upd      = sw_rst | wr_en;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q_r <= RST;
        end else if (upd) begin
            // locked bits hold, unlocked bits take the new value
            q_r <= (q_r & lock) | (load_nxt & ~lock);
        end
    end

    assign q = q_r;

endmodule

// >>> rtl/sgd_data_regs.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "sgd_cfg.svh"

module sgd_data_regs (
    input  wire logic                            clk,
    input  wire logic                            rstn,
    input  wire logic                            sw_rst,
    input  wire sgd_pkg::sgd_bus_s               bus,
    output logic      [`SGD_DATA_W-1:0]          rdata,
    input  wire logic [`SGD_BIDIR_N-1:0]         bidir_pin_i,
    output sgd_pkg::sgd_bidir_drv_s              bidir_pin,
    input  wire logic [`SGD_EVENT_N-1:0]         event_pin_i,
    input  wire logic [`SGD_OUTONLY_N-1:0]       out_pin_i,
    output sgd_pkg::sgd_out_drv_s                out_pin,
    input  wire logic [`SGD_INONLY_N-1:0]        inonly_pin_i
);
    import sgd_pkg::*;

    localparam int BN = `SGD_BIDIR_N;
    localparam int ON = `SGD_OUTONLY_N;

    sgd_reg_e             wsel;
    sgd_reg_e             rsel;
    sgd_data_t            rd_mux;
    sgd_data_t            rdata_r;

    logic [BN-1:0]        bidir_lock_r;
    logic [ON-1:0]        out_lock_r;

    logic [BN-1:0]        bidir_dout;
    logic [BN-1:0]        bidir_oe;
    logic [BN-1:0]        bidir_otype;
    logic [BN-1:0]        bidir_pu;
    logic [ON-1:0]        out_dout;
    logic [ON-1:0]        out_otype;
    logic [ON-1:0]        out_pu;
    logic [ON-1:0]        out_oe;

    sgd_data_t            bidir_din;
    sgd_data_t            misc_din;

    // address to register, shared by the write and the read path
    function automatic sgd_reg_e sgd_decode(input sgd_addr_t a);
        sgd_reg_e r;
        r = SGD_REG_NONE;
        case (a)
            `SGD_OFF_BIDIR_DOUT:  r = SGD_REG_BIDIR_DOUT;
            `SGD_OFF_BIDIR_DIN:   r = SGD_REG_BIDIR_DIN;
            `SGD_OFF_OUT_DOUT:    r = SGD_REG_OUT_DOUT;
            `SGD_OFF_MISC_DIN:    r = SGD_REG_MISC_DIN;
            `SGD_OFF_BIDIR_OE:    r = SGD_REG_BIDIR_OE;
            `SGD_OFF_BIDIR_OTYPE: r = SGD_REG_BIDIR_OTYPE;
            `SGD_OFF_BIDIR_PU:    r = SGD_REG_BIDIR_PU;
            `SGD_OFF_BIDIR_LOCK:  r = SGD_REG_BIDIR_LOCK;
            `SGD_OFF_OUT_OE:      r = SGD_REG_OUT_OE;
            `SGD_OFF_OUT_OTYPE:   r = SGD_REG_OUT_OTYPE;
            `SGD_OFF_OUT_PU:      r = SGD_REG_OUT_PU;
            `SGD_OFF_OUT_LOCK:    r = SGD_REG_OUT_LOCK;
            default:              r = SGD_REG_NONE;
        endcase
        return r;
    endfunction

    // open drain only pulls low, push-pull drives both levels
    function automatic logic sgd_pin_oe(input logic en,
                                        input logic push_pull,
                                        input logic d);
        return en & (push_pull | ~d);
    endfunction

    assign wsel = bus.wr ? sgd_decode(bus.addr) : SGD_REG_NONE;
    assign rsel = bus.rd ? sgd_decode(bus.addr) : SGD_REG_NONE;

    // lock bits: set only, cleared by the power-up reset alone
    // sticky lock
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bidir_lock_r <= '0;
        end else if (wsel == SGD_REG_BIDIR_LOCK) begin
            bidir_lock_r <= bidir_lock_r | bus.wdata[BN-1:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_lock_r <= '0;
        end else if (wsel == SGD_REG_OUT_LOCK) begin
            out_lock_r <= out_lock_r | bus.wdata[ON-1:0];
        end
    end

    sgd_lock_reg #(
        .W     (BN),
        .RST   (`SGD_RST_BIDIR_DOUT)
    ) u_bidir_dout (
        .clk   (clk),
        .rstn  (rstn),
        .sw_rst(sw_rst),
        .wr_en (wsel == SGD_REG_BIDIR_DOUT),
        .wdata (bus.wdata[BN-1:0]),
        .lock  (bidir_lock_r),
        .q     (bidir_dout)
    );

    sgd_lock_reg #(
        .W     (ON),
        .RST   (`SGD_RST_OUT_DOUT)
    ) u_out_dout (
        .clk   (clk),
        .rstn  (rstn),
        .sw_rst(sw_rst),
        .wr_en (wsel == SGD_REG_OUT_DOUT),
        .wdata (bus.wdata[ON-1:0]),
        .lock  (out_lock_r),
        .q     (out_dout)
    );

    sgd_lock_reg #(
        .W     (BN),
        .RST   (`SGD_RST_BIDIR_OE)
    ) u_bidir_oe (
        .clk   (clk),
        .rstn  (rstn),
        .sw_rst(sw_rst),
        .wr_en (wsel == SGD_REG_BIDIR_OE),
        .wdata (bus.wdata[BN-1:0]),
        .lock  (bidir_lock_r),
        .q     (bidir_oe)
    );

    sgd_lock_reg #(
        .W     (BN),
        .RST   (`SGD_RST_BIDIR_OTYPE)
    ) u_bidir_otype (
        .clk   (clk),
        .rstn  (rstn),
        .sw_rst(sw_rst),
        .wr_en (wsel == SGD_REG_BIDIR_OTYPE),
        .wdata (bus.wdata[BN-1:0]),
        .lock  (bidir_lock_r),
        .q     (bidir_otype)
    );

    sgd_lock_reg #(
        .W     (BN),
        .RST   (`SGD_RST_BIDIR_PU)
    ) u_bidir_pu (
        .clk   (clk),
        .rstn  (rstn),
        .sw_rst(sw_rst),
        .wr_en (wsel == SGD_REG_BIDIR_PU),
        .wdata (bus.wdata[BN-1:0]),
        .lock  (bidir_lock_r),
        .q     (bidir_pu)
    );

    sgd_lock_reg #(
        .W     (ON),
        .RST   (`SGD_RST_OUT_OTYPE)
    ) u_out_otype (
        .clk   (clk),
        .rstn  (rstn),
        .sw_rst(sw_rst),
        .wr_en (wsel == SGD_REG_OUT_OTYPE),
        .wdata (bus.wdata[ON-1:0]),
        .lock  (out_lock_r),
        .q     (out_otype)
    );

    sgd_lock_reg #(
        .W     (ON),
        .RST   (`SGD_RST_OUT_PU)
    ) u_out_pu (
        .clk   (clk),
        .rstn  (rstn),
        .sw_rst(sw_rst),
        .wr_en (wsel == SGD_REG_OUT_PU),
        .wdata (bus.wdata[ON-1:0]),
        .lock  (out_lock_r),
        .q     (out_pu)
    );

    assign out_oe = `SGD_RST_OUT_OE;

    // pin drivers, one slice per pin
    genvar g;
    generate
        for (g = 0; g < BN; g++) begin : g_bidir
            assign bidir_pin.o[g]  = bidir_dout[g];
            assign bidir_pin.oe[g] = sgd_pin_oe(bidir_oe[g],
                                                bidir_otype[g],
                                                bidir_dout[g]);
            assign bidir_pin.pu[g] = bidir_pu[g];
        end
        for (g = 0; g < ON; g++) begin : g_out
            assign out_pin.o[g]  = out_dout[g];
            assign out_pin.oe[g] = sgd_pin_oe(out_oe[g],
                                              out_otype[g],
                                              out_dout[g]);
            assign out_pin.pu[g] = out_pu[g];
        end
    endgenerate

    // live pin levels, sampled only when the read is taken
    // pin map
    always_comb begin
        bidir_din = '0;
        bidir_din[`SGD_BIDIR_DIN_LSB +: BN] = bidir_pin_i;
        bidir_din[`SGD_EVENT_DIN_LSB +: `SGD_EVENT_N] = event_pin_i;
    end

    always_comb begin
        misc_din = '0;
        misc_din[`SGD_OUT_DIN_LSB +: ON] = out_pin_i;
        misc_din[`SGD_INONLY_DIN_LSB +: `SGD_INONLY_N] = inonly_pin_i;
    end

    always_comb begin
        rd_mux = '0;
        case (rsel)
            SGD_REG_BIDIR_DOUT:  rd_mux[BN-1:0] = bidir_dout;
            SGD_REG_BIDIR_DIN:   rd_mux = bidir_din;
            SGD_REG_OUT_DOUT:    rd_mux[ON-1:0] = out_dout;
            SGD_REG_MISC_DIN:    rd_mux = misc_din;
            SGD_REG_BIDIR_OE:    rd_mux[BN-1:0] = bidir_oe;
            SGD_REG_BIDIR_OTYPE: rd_mux[BN-1:0] = bidir_otype;
            SGD_REG_BIDIR_PU:    rd_mux[BN-1:0] = bidir_pu;
            SGD_REG_BIDIR_LOCK:  rd_mux[BN-1:0] = bidir_lock_r;
            SGD_REG_OUT_OE:      rd_mux[ON-1:0] = out_oe;
            SGD_REG_OUT_OTYPE:   rd_mux[ON-1:0] = out_otype;
            SGD_REG_OUT_PU:      rd_mux[ON-1:0] = out_pu;
            SGD_REG_OUT_LOCK:    rd_mux[ON-1:0] = out_lock_r;
            default:             rd_mux = '0;
        endcase
    end

    // read data valid only in the cycle after the strobe, zero otherwise
    // input writes inert
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rd_mux;
        end
    end

    assign rdata = rdata_r;

endmodule

// >>> tb/sgd_data_regs_asserts.sv
`timescale 1ns/1ps
module sgd_data_regs_asserts (
    input wire logic                    clk,
    input wire logic                    rstn,
    input wire logic                    sw_rst,
    input wire sgd_pkg::sgd_bus_s       bus,
    input wire logic [7:0]              rdata,
    input wire logic [5:0]              bidir_pin_i,
    input wire sgd_pkg::sgd_bidir_drv_s bidir_pin,
    input wire logic [1:0]              event_pin_i,
    input wire logic [1:0]              out_pin_i,
    input wire sgd_pkg::sgd_out_drv_s   out_pin,
    input wire logic [1:0]              inonly_pin_i
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_rst;
        disable iff (1'b0) $rose(rstn) |->
            bidir_pin.o == 6'h3F && out_pin.o == 2'h3 && bidir_pin.oe == 6'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("bad preset");
    property p_idle;
        !bus.rd |=> rdata == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("rdata not idle");
    property p_din;
        bus.rd && bus.addr == 8'h09 |=> rdata[7:6] == $past(event_pin_i)
            && rdata[5:0] == $past(bidir_pin_i);
    endproperty
    a_din: assert property (p_din) else $error("bad din read");
    property p_misc;
        bus.rd && bus.addr == 8'h0B |=> rdata[7:4] == 4'h0
            && rdata[3:2] == $past(inonly_pin_i)
            && rdata[1:0] == $past(out_pin_i);
    endproperty
    a_misc: assert property (p_misc) else $error("bad misc read");
    property p_dout0;
        bus.rd && bus.addr == 8'h08 |=> rdata == {2'b00, $past(bidir_pin.o)};
    endproperty
    a_dout0: assert property (p_dout0)
        else $error("bad latch read");
    property p_dout1;
        bus.rd && bus.addr == 8'h0A |=> rdata == {6'h00, $past(out_pin.o)};
    endproperty
    a_dout1: assert property (p_dout1)
        else $error("bad latch read");
    property p_ro_wr;
        bus.wr && bus.addr inside {8'h09, 8'h0B} && !sw_rst |=>
            $stable(bidir_pin.o) && $stable(out_pin.o) && $stable(bidir_pin.oe);
    endproperty
    a_ro_wr: assert property (p_ro_wr) else $error("ro write acted");
    property p_hold;
        !bus.wr && !sw_rst |=> $stable(bidir_pin.o) && $stable(out_pin.o);
    endproperty
    a_hold: assert property (p_hold) else $error("latch moved");
    property p_out_en;
        (out_pin.oe | out_pin.o) == 2'b11;
    endproperty
    a_out_en: assert property (p_out_en)
        else $error("low not driven");
    c_din: cover property (bus.rd && bus.addr == 8'h09);
    c_wr: cover property (bus.wr && bus.addr == 8'h08);
    c_sw: cover property (sw_rst);
endmodule

// >>> tb/sgd_board.sv
`timescale 1ns/1ps
// board side: released pins float to pull-up or to what the board drives
module sgd_board (
    input wire sgd_pkg::sgd_bidir_drv_s bidir_pin,
    input wire sgd_pkg::sgd_out_drv_s   out_pin,
    input wire logic [5:0]              ext_bi,
    input wire logic [1:0]              ext_out,
    output logic [5:0]                  lvl_bi,
    output logic [1:0]                  lvl_out
);
    assign lvl_bi = (bidir_pin.oe & bidir_pin.o)
        | (~bidir_pin.oe & (bidir_pin.pu | ext_bi));
    assign lvl_out = (out_pin.oe & out_pin.o)
        | (~out_pin.oe & (out_pin.pu | ext_out));
endmodule

// >>> tb/sgd_data_regs_test.sv
`timescale 1ns/1ps
module sgd_data_regs_test;
    import sgd_pkg::*;
    logic           clk, rstn, sw_rst;
    sgd_bus_s       bus;
    logic [7:0]     rdata, q;
    logic [5:0]     ext_bi, lvl_bi;
    logic [1:0]     ev, ext_out, lvl_out, ino;
    sgd_bidir_drv_s bidir_pin;
    sgd_out_drv_s   out_pin;
    logic [31:0]    seed;
    int             error_cnt, check_count, m0, m1, k0, k1, i;

    sgd_data_regs uut (.clk(clk), .rstn(rstn), .sw_rst(sw_rst), .bus(bus),
        .rdata(rdata), .bidir_pin_i(lvl_bi), .bidir_pin(bidir_pin),
        .event_pin_i(ev), .out_pin_i(lvl_out), .out_pin(out_pin),
        .inonly_pin_i(ino));
    sgd_board brd (.bidir_pin(bidir_pin), .out_pin(out_pin), .ext_bi(ext_bi),
        .ext_out(ext_out), .lvl_bi(lvl_bi), .lvl_out(lvl_out));

    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    // whole run is well under 2000 cycles
    initial begin
        #1000000;
        error_cnt++;
        conclude();
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one strobe cycle, then idle; read data lands in q
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk);
        bus <= '0;
        #1 q = rdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
        if (a == 8'h08) m0 = (m0 & k0) | (d & ~k0 & 8'h3F);
        if (a == 8'h0A) m1 = (m1 & k1) | (d & ~k1 & 8'h03);
        if (a == 8'h23) k0 |= d & 8'h3F;
        if (a == 8'h27) k1 |= d & 8'h03;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(q, e);
    endtask
    task automatic srst();
        @(posedge clk);
        sw_rst <= 1'b1;
        @(posedge clk);
        sw_rst <= 1'b0;
        m0 = (m0 & k0) | (8'h3F & ~k0);
        m1 = (m1 & k1) | (8'h03 & ~k1);
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        rstn = 0;
        sw_rst = 0;
        bus = '0;
        {ext_bi, ext_out, ev, ino} = '0;
        seed = 32'h9DB3F52A;
        {m0, m1, k0, k1} = {32'h3F, 32'h3, 32'h0, 32'h0};
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        rdc(8'h08, 8'h3F);
        rdc(8'h0A, 8'h03);
        chk({2'b00, bidir_pin.oe}, 8'h00);
        rdc(8'h40, 8'h00);
        for (i = 0; i < 40; i++) begin
            seed = xs(seed);
            // pull-ups off so released bidir pins show the board level
            if (i == 10) wr(8'h22, 8'h00);
            if (i == 20) begin
                wr(8'h20, 8'h3F);
                wr(8'h21, 8'h3F);
                wr(8'h25, 8'h03);
            end
            wr(8'h08, seed[7:0]);
            wr(8'h0A, seed[15:8]);
            wr(8'h09, seed[23:16]);
            wr(8'h0B, seed[31:24]);
            rdc(8'h08, m0[7:0]);
            rdc(8'h0A, m1[7:0]);
            chk({6'h00, lvl_out}, m1[7:0]);
            if (i > 20) chk({2'b00, lvl_bi}, m0[7:0]);
            if (i >= 10 && i < 20)
                chk({2'b00, lvl_bi}, {2'b00, ext_bi});
            @(posedge clk);
            ext_bi <= seed[5:0];
            ev <= seed[7:6];
            ino <= seed[9:8];
            ext_out <= seed[11:10];
            @(posedge clk);
            #1;
            rdc(8'h09, {ev, lvl_bi});
            rdc(8'h0B, {4'h0, ino, lvl_out});
        end
        wr(8'h23, 8'h05);
        wr(8'h27, 8'h01);
        wr(8'h23, 8'h00);
        rdc(8'h23, 8'h05);
        for (i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr(8'h08, seed[7:0]);
            wr(8'h0A, seed[15:8]);
            rdc(8'h08, m0[7:0]);
            rdc(8'h0A, m1[7:0]);
            srst();
            rdc(8'h20, 8'h05);
            rdc(8'h08, m0[7:0]);
            rdc(8'h0A, m1[7:0]);
        end
        // power-up reset is the only way out of a lock
        @(posedge clk);
        rstn <= 1'b0;
        {m0, m1, k0, k1} = {32'h3F, 32'h3, 32'h0, 32'h0};
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rdc(8'h08, 8'h3F);
        wr(8'h08, 8'h00);
        rdc(8'h08, 8'h00);
        conclude();
    end
endmodule

bind sgd_data_regs sgd_data_regs_asserts chk_i (.clk(clk), .rstn(rstn),
    .sw_rst(sw_rst), .bus(bus), .rdata(rdata), .bidir_pin_i(bidir_pin_i),
    .bidir_pin(bidir_pin), .event_pin_i(event_pin_i), .out_pin_i(out_pin_i),
    .out_pin(out_pin), .inonly_pin_i(inonly_pin_i));
